// File: rsf_ctrl.sv
// Contract
// (R1) The receive start threshold is 3 bits: control bits 6-5 low, 0x33 bit 1 high.
// (R2) At threshold 2 reads begin once the write pointer leads by 4 entries.
// (R3) Transmit and receive sync FIFOs each hold 8 entries.
// (R4) Each threshold step up or down adds or removes one read cycle of latency; the code caps the start level at 8, so step 6 to 7 adds none.
// (R5) Software picks a threshold with margin against under- and overflow.
// (R6) The transmit start threshold is 3 bits: bits 4-3 low, 0x33 bit 0 high.
// (R7) Transmit skew bit 0 means clock shifted to data, 1 means aligned.
// (R8) Receive skew bit 0 drives the clock shifted to data, 1 aligned.
// (R9) The control register at 0x32 resets to 00d0.
// (R10) The transmit error mask enable at bit 2 is plain storage, reset zero.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "rsf_regs.svh"

module rsf_ctrl #(
  parameter int DATA_W    = 8,
  parameter int SYNC_DEPTH = 8,
  parameter int BUF_DEPTH = 16,
  parameter int PHY_DIV   = 12
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Avalon-MM slave, byte address
  input  wire logic [9:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic [1:0]             avs_response,
  output logic                   avs_waitrequest,
  // Transmit link from the MAC
  input  wire logic              link_tx_clk,
  input  wire logic [DATA_W-1:0] link_txd,
  input  wire logic              link_tx_ctl,
  // Receive link to the MAC
  output logic                   link_rx_clk,
  output logic [DATA_W-1:0]      link_rxd,
  output logic                   link_rx_ctl,
  // Transmit stream toward the PHY core
  output logic                   phy_tx_valid,
  input  wire logic              phy_tx_ready,
  output logic [DATA_W-1:0]      phy_tx_data,
  // Receive stream from the PHY core
  input  wire logic              phy_rx_valid,
  output logic                   phy_rx_ready,
  input  wire logic [DATA_W-1:0] phy_rx_data
);
  localparam int SLW = $clog2(SYNC_DEPTH) + 1;
  localparam int DW  = $clog2(PHY_DIV) + 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(PHY_DIV - 1);
  localparam logic [DW-1:0] DIV_HALF = DW'(PHY_DIV / 2);

  function automatic logic [7:0] reg_index(input logic [9:0] addr);
    reg_index = addr[9:2];
  endfunction

  function automatic logic reg_mapped(input logic [9:0] addr);
    reg_mapped = (addr[1:0] == 2'h0) &&
                 ((reg_index(addr) == `RSF_IDX_CTRL) ||
                  (reg_index(addr) == `RSF_IDX_CTRL2) ||
                  (reg_index(addr) == `RSF_IDX_STAT));
  endfunction

  function automatic rsf_pkg::rsf_reg16_t merge16(
    input rsf_pkg::rsf_reg16_t old_v,
    input logic [31:0]         wdata,
    input logic [3:0]          be,
    input rsf_pkg::rsf_reg16_t mask
  );
    rsf_pkg::rsf_reg16_t lanes;
    lanes   = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge16 = (old_v & ~lanes) | (wdata[15:0] & lanes);
  endfunction

  // Register and bus state
  rsf_pkg::rsf_reg16_t ctrl_r, ctrl_nxt, ctrl2_r, ctrl2_nxt;
  rsf_pkg::rsf_reg16_t stat_sticky_r, stat_sticky_nxt, stat_view;
  logic [31:0] rdata_nxt;
  logic [1:0]  resp_nxt;
  logic        wait_nxt, wr_commit, rd_start;
  logic [2:0]  tx_thr, rx_thr;
  logic        tx_align, rx_align;

  // Link input synchronisers
  logic [1:0]        tclk_sync_r;
  logic              tclk_prev_r;
  logic [DATA_W-1:0] txd_s1_r, txd_s2_r;
  logic              tctl_s1_r, tctl_s2_r;
  logic              tclk_rise, tclk_fall, tx_wr_stb;

  // Read pacing and receive clock
  logic [DW-1:0] div_r, div_nxt;
  logic          rx_clk_nxt, phy_tick, phy_half, rx_rise, rx_fall, rx_edge;

  // FIFO connections
  logic              tx_rd_valid, tx_run, tx_ovf, tx_udf, buf_in_ready;
  logic [DATA_W:0]   tx_rd_data;
  logic [SLW-1:0]    tx_level, rx_level;
  logic              rx_rd_valid, rx_run, rx_ovf, rx_udf, rx_rd_stb;
  logic [DATA_W:0]   rx_rd_data;
  logic [DATA_W-1:0] rxd_nxt;
  logic              rx_ctl_nxt;
  logic [DATA_W:0]   buf_out_data;

  assign tx_thr   = {ctrl2_r[`RSF_CTRL2_TX_THR_MSB],
                     ctrl_r[`RSF_CTRL_TX_THR_LSB +: 2]}; // (R6)
  assign rx_thr   = {ctrl2_r[`RSF_CTRL2_RX_THR_MSB],
                     ctrl_r[`RSF_CTRL_RX_THR_LSB +: 2]}; // (R1)
  assign tx_align = ctrl_r[`RSF_CTRL_TX_ALIGN];
  assign rx_align = ctrl_r[`RSF_CTRL_RX_ALIGN];

  // Register file and bus slave
  always_comb begin
    stat_view = stat_sticky_r;
    stat_view[`RSF_STAT_TX_RUN] = tx_run;
    stat_view[`RSF_STAT_RX_RUN] = rx_run;
    stat_view[`RSF_STAT_TX_LVL_LSB +: 4] = 4'(tx_level);
    stat_view[`RSF_STAT_RX_LVL_LSB +: 4] = 4'(rx_level);

    wr_commit = avs_write && !avs_waitrequest && reg_mapped(avs_address);
    rd_start  = avs_read && avs_waitrequest;
    wait_nxt  = !((avs_read || avs_write) && avs_waitrequest);

    ctrl_nxt  = ctrl_r;
    ctrl2_nxt = ctrl2_r;
    stat_sticky_nxt = stat_sticky_r;
    if (wr_commit) begin
      unique case (reg_index(avs_address))
        `RSF_IDX_CTRL:
          ctrl_nxt = merge16(ctrl_r, avs_writedata, avs_byteenable,
                             `RSF_CTRL_WMASK); // (R10)
        `RSF_IDX_CTRL2:
          ctrl2_nxt = merge16(ctrl2_r, avs_writedata, avs_byteenable,
                              `RSF_CTRL2_WMASK); // (R1) (R6)
        default:
          stat_sticky_nxt = stat_sticky_r & ~({{8{avs_byteenable[1]}},
            {8{avs_byteenable[0]}}} & avs_writedata[15:0] &
            `RSF_STAT_W1C_MASK);
      endcase
    end
    // Hardware set wins over a same-cycle clear
    stat_sticky_nxt[`RSF_STAT_TX_OVF] = stat_sticky_nxt[`RSF_STAT_TX_OVF]
                                        | tx_ovf;
    stat_sticky_nxt[`RSF_STAT_TX_UDF] = stat_sticky_nxt[`RSF_STAT_TX_UDF]
                                        | tx_udf;
    stat_sticky_nxt[`RSF_STAT_RX_OVF] = stat_sticky_nxt[`RSF_STAT_RX_OVF]
                                        | rx_ovf;
    stat_sticky_nxt[`RSF_STAT_RX_UDF] = stat_sticky_nxt[`RSF_STAT_RX_UDF]
                                        | rx_udf;

    rdata_nxt = avs_readdata;
    resp_nxt  = avs_response;
    if (rd_start || (avs_write && avs_waitrequest)) begin
      rdata_nxt = 32'h0000_0000;
      resp_nxt  = reg_mapped(avs_address) ? `RSF_RESP_OKAY
                                          : `RSF_RESP_DECERR;
      if (rd_start && reg_mapped(avs_address)) begin
        unique case (reg_index(avs_address))
          `RSF_IDX_CTRL:  rdata_nxt = {16'h0000, ctrl_r};
          `RSF_IDX_CTRL2: rdata_nxt = {16'h0000, ctrl2_r};
          default:        rdata_nxt = {16'h0000, stat_view};
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r          <= `RSF_CTRL_RESET; // (R9)
      ctrl2_r         <= `RSF_CTRL2_RESET;
      stat_sticky_r   <= 16'h0000;
      avs_readdata    <= 32'h0000_0000;
      avs_response    <= `RSF_RESP_OKAY;
      avs_waitrequest <= 1'b1;
    end else begin
      ctrl_r          <= ctrl_nxt;
      ctrl2_r         <= ctrl2_nxt;
      stat_sticky_r   <= stat_sticky_nxt;
      avs_readdata    <= rdata_nxt;
      avs_response    <= resp_nxt;
      avs_waitrequest <= wait_nxt;
    end
  end

  // Transmit link capture; edges found on the synchronised clock
  always_comb begin
    tclk_rise = tclk_sync_r[1] && !tclk_prev_r;
    tclk_fall = !tclk_sync_r[1] && tclk_prev_r;
    // Shifted clock: sample at rising edge; aligned: mid-bit, falling
    tx_wr_stb = (tx_align ? tclk_fall : tclk_rise) && tctl_s2_r; // (R7)
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tclk_sync_r <= 2'h0;
      tclk_prev_r <= 1'b0;
      txd_s1_r    <= '0;
      txd_s2_r    <= '0;
      tctl_s1_r   <= 1'b0;
      tctl_s2_r   <= 1'b0;
    end else begin
      tclk_sync_r <= {tclk_sync_r[0], link_tx_clk};
      tclk_prev_r <= tclk_sync_r[1];
      txd_s1_r    <= link_txd;
      txd_s2_r    <= txd_s1_r;
      tctl_s1_r   <= link_tx_ctl;
      tctl_s2_r   <= tctl_s1_r;
    end
  end

  rsf_sync_fifo #(
    .DATA_W (DATA_W + 1),
    .DEPTH  (SYNC_DEPTH)
  ) u_tx_sync (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .threshold (tx_thr),
    .wr_stb    (tx_wr_stb),
    .wr_data   ({tctl_s2_r, txd_s2_r}),
    .rd_stb    (phy_tick),
    .rd_hold   (!buf_in_ready),
    .rd_valid  (tx_rd_valid),
    .rd_data   (tx_rd_data),
    .running   (tx_run),
    .level     (tx_level),
    .overflow  (tx_ovf),
    .underflow (tx_udf)
  );

  rsf_stream_fifo #(
    .WIDTH (DATA_W + 1),
    .DEPTH (BUF_DEPTH)
  ) u_tx_buf (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (tx_rd_valid),
    .in_ready  (buf_in_ready),
    .in_data   (tx_rd_data),
    .out_valid (phy_tx_valid),
    .out_ready (phy_tx_ready),
    .out_data  (buf_out_data)
  );
  assign phy_tx_data = buf_out_data[DATA_W-1:0];

  // Read pacing divider; also makes the receive link clock
  always_comb begin
    phy_tick   = (div_r == DIV_LAST);
    phy_half   = (div_r == DIV_HALF - DW'(1));
    div_nxt    = phy_tick ? '0 : div_r + DW'(1);
    // Clock edges lag the strobes by one cycle, as the read data does
    rx_rise    = (div_r == '0);
    rx_fall    = (div_r == DIV_HALF);
    rx_clk_nxt = rx_rise ? 1'b1 : (rx_fall ? 1'b0 : link_rx_clk);
    // Aligned: data moves with the rising edge; shifted: with the falling
    rx_rd_stb  = rx_align ? phy_tick : phy_half; // (R8)
    rx_edge    = rx_align ? rx_rise : rx_fall; // (R8)
    rxd_nxt    = rx_rd_valid ? rx_rd_data[DATA_W-1:0] : link_rxd;
    rx_ctl_nxt = rx_rd_valid ? 1'b1 : (rx_edge ? 1'b0 : link_rx_ctl);
  end

  rsf_sync_fifo #(
    .DATA_W (DATA_W + 1),
    .DEPTH  (SYNC_DEPTH)
  ) u_rx_sync (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .threshold (rx_thr),
    .wr_stb    (phy_rx_valid && phy_rx_ready),
    .wr_data   ({1'b1, phy_rx_data}),
    .rd_stb    (rx_rd_stb),
    .rd_hold   (1'b0),
    .rd_valid  (rx_rd_valid),
    .rd_data   (rx_rd_data),
    .running   (rx_run),
    .level     (rx_level),
    .overflow  (rx_ovf),
    .underflow (rx_udf)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r        <= '0;
      link_rx_clk  <= 1'b0;
      link_rxd     <= '0;
      link_rx_ctl  <= 1'b0;
      phy_rx_ready <= 1'b0;
    end else begin
      div_r        <= div_nxt;
      link_rx_clk  <= rx_clk_nxt;
      link_rxd     <= rxd_nxt;
      link_rx_ctl  <= rx_ctl_nxt;
      phy_rx_ready <= (rx_level < SLW'(SYNC_DEPTH - 1)); // (R3)
    end
  end

endmodule // rsf_ctrl
`default_nettype wire

// File: rsf_regs.svh
`ifndef RSF_REGS_SVH
`define RSF_REGS_SVH

// Register indices; byte address is four times the index
`define RSF_IDX_CTRL        8'h32
`define RSF_IDX_CTRL2       8'h33
`define RSF_IDX_STAT        8'h34

`define RSF_CTRL_RESET      16'h00d0
`define RSF_CTRL_WMASK      16'h0bff
`define RSF_CTRL2_RESET     16'h0000
`define RSF_CTRL2_WMASK     16'h001f
`define RSF_STAT_W1C_MASK   16'h000f

// Control register fields
`define RSF_CTRL_RX_THR_LSB 5
`define RSF_CTRL_TX_THR_LSB 3
`define RSF_CTRL_TX_ERR_MSK 2
`define RSF_CTRL_TX_ALIGN   1
`define RSF_CTRL_RX_ALIGN   0

// Companion register fields
`define RSF_CTRL2_RX_THR_MSB 1
`define RSF_CTRL2_TX_THR_MSB 0

// Status register fields
`define RSF_STAT_TX_OVF     0
`define RSF_STAT_TX_UDF     1
`define RSF_STAT_RX_OVF     2
`define RSF_STAT_RX_UDF     3
`define RSF_STAT_TX_RUN     4
`define RSF_STAT_RX_RUN     5
`define RSF_STAT_TX_LVL_LSB 8
`define RSF_STAT_RX_LVL_LSB 12

// Fill level that starts reads is threshold plus this offset, capped at the FIFO depth
`define RSF_THR_LEVEL_OFS   2

`define RSF_RESP_OKAY       2'h0
`define RSF_RESP_DECERR     2'h3

`endif

// File: rsf_pkg.sv
package rsf_pkg;

  typedef logic [15:0] rsf_reg16_t;

  typedef enum logic {
    RSF_FILL,
    RSF_RUN
  } rsf_rd_state_t;

endpackage

// File: rsf_sync_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsf_regs.svh"

module rsf_sync_fifo #(
  parameter int DATA_W = 9,
  parameter int DEPTH  = 8
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [2:0]            threshold,
  input  wire logic                  wr_stb,
  input  wire logic [DATA_W-1:0]     wr_data,
  input  wire logic                  rd_stb,
  input  wire logic                  rd_hold,
  output logic                       rd_valid,
  output logic [DATA_W-1:0]          rd_data,
  output logic                       running,
  output logic [$clog2(DEPTH):0]     level,
  output logic                       overflow,
  output logic                       underflow
);
  localparam int AW = $clog2(DEPTH);

  logic [DATA_W-1:0]     mem_r [DEPTH];
  logic [AW:0]           wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [AW+1:0]         start_lvl;
  logic                  do_wr, do_rd, ovf_nxt, udf_nxt;
  rsf_pkg::rsf_rd_state_t st_r, st_nxt;

  assign level   = wptr_r - rptr_r;
  assign running = (st_r == rsf_pkg::RSF_RUN);

  always_comb begin
    start_lvl = (AW+2)'(threshold) + (AW+2)'(`RSF_THR_LEVEL_OFS); // (R2) (R4)
    if (start_lvl > (AW+2)'(DEPTH))
      start_lvl = (AW+2)'(DEPTH);
    do_wr    = wr_stb && (level != (AW+1)'(DEPTH)); // (R3)
    ovf_nxt  = wr_stb && !do_wr;
    do_rd    = 1'b0;
    udf_nxt  = 1'b0;
    st_nxt   = st_r;
    unique case (st_r)
      rsf_pkg::RSF_FILL: begin
        if ({1'b0, level} >= start_lvl) // (R2) (R4)
          st_nxt = rsf_pkg::RSF_RUN;
      end
      rsf_pkg::RSF_RUN: begin
        if (rd_stb && !rd_hold) begin
          if (level == '0) begin
            udf_nxt = 1'b1;
            st_nxt  = rsf_pkg::RSF_FILL;
          end else begin
            do_rd = 1'b1;
          end
        end
      end
    endcase
    wptr_nxt = do_wr ? wptr_r + (AW+1)'(1) : wptr_r;
    rptr_nxt = do_rd ? rptr_r + (AW+1)'(1) : rptr_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r    <= '0;
      rptr_r    <= '0;
      st_r      <= rsf_pkg::RSF_FILL;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
      overflow  <= 1'b0;
      underflow <= 1'b0;
    end else begin
      wptr_r    <= wptr_nxt;
      rptr_r    <= rptr_nxt;
      st_r      <= st_nxt;
      rd_valid  <= do_rd;
      rd_data   <= mem_r[rptr_r[AW-1:0]];
      overflow  <= ovf_nxt;
      underflow <= udf_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr)
      mem_r[wptr_r[AW-1:0]] <= wr_data;
  end

endmodule // rsf_sync_fifo
`default_nettype wire

// File: rsf_stream_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module rsf_stream_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r, wp_nxt, rp_r, rp_nxt, cnt;
  logic             push, pop, ov_nxt;

  assign cnt      = wp_r - rp_r;
  assign in_ready = (cnt != (AW+1)'(DEPTH));

  always_comb begin
    push   = in_valid && in_ready;
    pop    = (cnt != '0) && (!out_valid || out_ready);
    ov_nxt = pop || (out_valid && !out_ready);
    wp_nxt = push ? wp_r + (AW+1)'(1) : wp_r;
    rp_nxt = pop ? rp_r + (AW+1)'(1) : rp_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r      <= '0;
      rp_r      <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      wp_r      <= wp_nxt;
      rp_r      <= rp_nxt;
      out_valid <= ov_nxt;
      if (pop)
        out_data <= mem_r[rp_r[AW-1:0]];
    end
  end

  always_ff @(posedge clk) begin
    if (push)
      mem_r[wp_r[AW-1:0]] <= in_data;
  end

endmodule // rsf_stream_fifo
`default_nettype wire

// File: rsf_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
module rsf_mac_model (
  output logic       tx_clk,
  output logic [7:0] txd,
  output logic       tx_ctl
);
  initial begin
    tx_clk = 1'b0;
    txd    = 8'h00;
    tx_ctl = 1'b0;
  end
  // Data and valid stand only around the capturing edge
  task automatic send(input logic aligned, input logic [7:0] first,
                      input int n);
    logic cap;
    cap = ~aligned;
    for (int i = 0; i < n; i++) begin
      tx_clk = ~cap;
      #31.0;
      txd    = first + i[7:0];
      tx_ctl = 1'b1;
      #31.5;
      tx_clk = cap;
      #31.0;
      txd    = ~txd;
      tx_ctl = 1'b0;
      #31.5;
    end
    tx_clk = 1'b0;
  endtask
endmodule // rsf_mac_model
`default_nettype wire

// File: rsf_ctrl_props.sv
`timescale 1ns/10ps
`default_nettype none
module rsf_ctrl_props #(
  parameter int DATA_W  = 8,
  parameter int PHY_DIV = 12
) (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [9:0]        avs_address,
  input wire logic [31:0]       avs_writedata,
  input wire logic [31:0]       avs_readdata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [1:0]        avs_response,
  input wire logic              avs_waitrequest,
  input wire logic              link_tx_clk,
  input wire logic              link_tx_ctl,
  input wire logic [DATA_W-1:0] link_txd,
  input wire logic [DATA_W-1:0] link_rxd,
  input wire logic [DATA_W-1:0] phy_tx_data,
  input wire logic [DATA_W-1:0] phy_rx_data,
  input wire logic              link_rx_clk,
  input wire logic              link_rx_ctl,
  input wire logic              phy_tx_valid,
  input wire logic              phy_tx_ready,
  input wire logic              phy_rx_valid,
  input wire logic              phy_rx_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");
  chk_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one cycle");
  chk_wait_idle: assert property (
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  chk_bad_addr: assert property (
    (avs_read || avs_write) && avs_waitrequest && avs_address[1:0] != 2'h0
    |=> avs_response == 2'h3 && avs_readdata == 32'h0)
    else $error("misaligned access not refused");
  chk_ctrl_read: assert property (
    avs_read && avs_waitrequest && avs_address == 10'h0c8
    |=> avs_response == 2'h0 && avs_readdata[15:12] == 4'h0)
    else $error("control read wrong");
  chk_upper_zero: assert property (
    !avs_waitrequest |-> avs_readdata[31:16] == 16'h0)
    else $error("upper read bits set");
  chk_tx_hold: assert property (
    phy_tx_valid && !phy_tx_ready |=> phy_tx_valid && $stable(phy_tx_data))
    else $error("tx word dropped while stalled");
  chk_rx_edge: assert property (
    $changed(link_rxd) |-> $changed(link_rx_clk))
    else $error("rx data moved off clock edge");
endmodule // rsf_ctrl_props
bind rsf_ctrl rsf_ctrl_props #(.DATA_W(DATA_W), .PHY_DIV(PHY_DIV))
  rsf_ctrl_props_inst (
  .ref_clk, .rst_n, .avs_read, .avs_write, .avs_address, .avs_writedata,
  .avs_readdata, .avs_byteenable, .avs_response, .avs_waitrequest,
  .link_tx_clk, .link_tx_ctl, .link_txd, .link_rxd, .phy_tx_data,
  .phy_rx_data, .link_rx_clk, .link_rx_ctl, .phy_tx_valid, .phy_tx_ready,
  .phy_rx_valid, .phy_rx_ready);
`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [9:0]  a;
    logic [15:0] d;
    logic [3:0]  be;
    logic [15:0] e;
    logic [1:0]  rsp;
  } rsf_row_t;
  logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, rx_al;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response, r;
  logic        link_tx_clk, link_tx_ctl, link_rx_clk, link_rx_ctl, rx_pc;
  logic [7:0]  link_txd, link_rxd, phy_tx_data, phy_rx_data, rx_pd;
  logic        phy_tx_valid, phy_tx_ready, phy_rx_valid, phy_rx_ready, rx_pl;
  int          fails, comparisons, cycles, tx_out, tx_in, rx_out, rx_in;
  int          bad, b, st;
  rsf_row_t    rows [6] = '{
    '{10'h0c8, 16'hffff, 4'h3, 16'h0bff, 2'h0},
    '{10'h0c8, 16'h0000, 4'h3, 16'h0000, 2'h0},
    '{10'h0c8, 16'hffff, 4'h1, 16'h00ff, 2'h0},
    '{10'h0cc, 16'hffff, 4'h3, 16'h001f, 2'h0},
    '{10'h3fc, 16'hffff, 4'h3, 16'h0000, 2'h3},
    '{10'h0c9, 16'hffff, 4'h3, 16'h0000, 2'h3}};

  rsf_ctrl rsf_ctrl_inst (
    .ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_response, .avs_waitrequest,
    .link_tx_clk, .link_txd, .link_tx_ctl, .link_rx_clk, .link_rxd,
    .link_rx_ctl, .phy_tx_valid, .phy_tx_ready, .phy_tx_data, .phy_rx_valid,
    .phy_rx_ready, .phy_rx_data);
  rsf_mac_model rsf_mac_model_inst (
    .tx_clk(link_tx_clk), .txd(link_txd), .tx_ctl(link_tx_ctl));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task end_sim;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  // Output monitors; expected bytes run in sending order
  always @(posedge ref_clk) begin
    if (phy_tx_valid === 1'b1 && phy_tx_ready === 1'b1) begin
      chk({24'h0, phy_tx_data}, {24'h0, tx_out[7:0]}, "tx data");
      tx_out++;
    end
    if (link_rxd !== rx_pd && (link_rx_clk !== rx_al || rx_pc !== ~rx_al))
      bad++;
    if (link_rx_ctl === 1'b1 && (rx_pl !== 1'b1 || link_rxd !== rx_pd)) begin
      chk({24'h0, link_rxd}, {24'h0, rx_out[7:0]}, "rx data");
      rx_out++;
    end
    rx_pd <= link_rxd;
    rx_pc <= link_rx_clk;
    rx_pl <= link_rx_ctl;
  end

  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [15:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= {16'h0, d};
    avs_byteenable <= be;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    r = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic send_tx(input logic al, input int n);
    rsf_mac_model_inst.send(al, tx_in[7:0], n);
    tx_in += n;
    repeat (150) @(posedge ref_clk);
  endtask

  task automatic feed(input int n);
    for (int i = 0; i < n; i++) begin
      phy_rx_valid <= 1'b1;
      phy_rx_data  <= rx_in[7:0];
      @(posedge ref_clk);
      while (phy_rx_ready !== 1'b1) @(posedge ref_clk);
      rx_in++;
    end
    phy_rx_valid <= 1'b0;
    phy_rx_data  <= ~phy_rx_data;
    repeat (150) @(posedge ref_clk);
  endtask

  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {phy_tx_ready, phy_rx_valid, phy_rx_data, rx_al} = '0;
    {rx_pd, rx_pc, rx_pl} = '0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].be);
      bus(1'b0, rows[i].a, 16'h0, 4'h0);
      chk(q, {16'h0, rows[i].e}, "reg");
      chk({30'h0, r}, {30'h0, rows[i].rsp}, "resp");
    end
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, 10'h0c8, 16'h0, 4'h0);
    chk(q, 32'h00d0, "ctrl reset");
    bus(1'b0, 10'h0cc, 16'h0, 4'h0);
    chk(q, 32'h0000, "ctrl2 reset");
    phy_tx_ready <= 1'b1;
    for (int t = 0; t < 8; t++) begin
      st = (t > 5) ? 8 : t + 2;
      bus(1'b1, 10'h0c8, 16'h00c0 | {11'h0, t[1:0], 3'h0}, 4'h3);
      bus(1'b1, 10'h0cc, {15'h0, t[2]}, 4'h3);
      b = tx_out;
      send_tx(1'b0, st - 1);
      chk(tx_out, b, "tx early");
      send_tx(1'b0, 1);
      chk(tx_out, b + st, "tx start");
    end
    bus(1'b0, 10'h0d0, 16'h0, 4'h0);
    chk(q, 32'h0002, "tx status");
    bus(1'b1, 10'h0d0, 16'h000f, 4'h3);
    bus(1'b0, 10'h0d0, 16'h0, 4'h0);
    chk(q, 32'h0000, "status clear");
    bus(1'b1, 10'h0cc, 16'h0000, 4'h3);
    bus(1'b1, 10'h0c8, 16'h00d2, 4'h3);
    b = tx_out;
    send_tx(1'b1, 4);
    chk(tx_out, b + 4, "tx aligned");
    bus(1'b1, 10'h0c8, 16'h00d0, 4'h3);
    phy_tx_ready <= 1'b0;
    b = tx_out;
    send_tx(1'b0, 30);
    bus(1'b0, 10'h0d0, 16'h0, 4'h0);
    chk({31'h0, q[0]}, 32'h1, "tx overflow");
    chk({28'h0, q[11:8]}, 32'h8, "tx level");
    for (int k = 0; k < 300; k++) begin
      @(posedge ref_clk);
      phy_tx_ready <= k[1];
    end
    phy_tx_ready <= 1'b1;
    repeat (50) @(posedge ref_clk);
    chk({31'h0, tx_out - b >= 24 && tx_out - b <= 25}, 32'h1, "kept");
    chk({31'h0, phy_tx_valid}, 32'h0, "tx drained");
    tx_in = tx_out;
    for (int m = 0; m < 2; m++) begin
      st = m ? 7 : 4;
      bus(1'b1, 10'h0c8, m ? 16'h00b1 : 16'h00d0, 4'h3);
      bus(1'b1, 10'h0cc, m ? 16'h0002 : 16'h0000, 4'h3);
      rx_al = m[0];
      b = rx_out;
      feed(st - 1);
      chk(rx_out, b, "rx early");
      feed(1);
      chk(rx_out, b + st, "rx start");
    end
    chk(bad, 0, "rx edge");
    bus(1'b0, 10'h0d0, 16'h0, 4'h0);
    chk({31'h0, q[3]}, 32'h1, "rx underflow");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
